/* include/flash_pkg.sv */
// Purpose: shared constants for the reset and parameter-table command block
// Assumes: 250 MHz system clock, serial clock sampled as a plain input
// Notes: table words are little-endian, byte 0 in bits 7:0
package flash_pkg;

  // ==========================================================================
  // clock and timing
  localparam int CLK_PERIOD_NS = 4;
  localparam int RST_RECOVERY_NS_DEF = 30000;

  // ==========================================================================
  // opcodes
  localparam logic [7:0] OP_RESET_ARM = 8'h66;
  localparam logic [7:0] OP_RESET_EXEC = 8'h99;
  localparam logic [7:0] OP_PARAM_READ = 8'h5A;

  // ==========================================================================
  // frame bit positions, counted in rising serial clock edges
  localparam logic [5:0] BITS_OPCODE = 6'h08;
  localparam logic [5:0] BITS_ADDR_END = 6'h20;
  localparam logic [5:0] BITS_DATA_START = 6'h28;
  localparam int TABLE_ADDR_W = 11;
  localparam int DATA_W = 8;
  localparam int FIFO_DEPTH = 32;

  // ==========================================================================
  // table header word offsets and contents
  localparam logic [TABLE_ADDR_W-1:0] OFS_PARAM_SIGNATURE = 11'h000;
  localparam logic [TABLE_ADDR_W-1:0] OFS_PARAM_HEADER_REVISION_COUNT = 11'h004;
  localparam logic [TABLE_ADDR_W-1:0] OFS_BASIC_TABLE_HEADER = 11'h008;
  localparam logic [TABLE_ADDR_W-1:0] OFS_BASIC_TABLE_POINTER = 11'h00C;
  localparam logic [TABLE_ADDR_W-1:0] OFS_VENDOR_TABLE_HEADER = 11'h010;
  localparam logic [TABLE_ADDR_W-1:0] OFS_VENDOR_TABLE_POINTER = 11'h014;
  localparam logic [31:0] RST_PARAM_SIGNATURE = 32'h50444653;
  localparam logic [31:0] RST_PARAM_HEADER_REVISION_COUNT = 32'hFF020105;
  localparam logic [31:0] RST_BASIC_TABLE_HEADER = 32'h10010000;
  localparam logic [31:0] RST_BASIC_TABLE_POINTER = 32'hFF000040;
  localparam logic [23:0] RST_VENDOR_TABLE_HEADER_UPPER = 24'h040100;
  localparam logic [31:0] RST_VENDOR_TABLE_POINTER = 32'hFF0000C0;
  localparam logic [7:0] BLANK_BYTE = 8'hFF;

  // ==========================================================================
  // frame decoder states
  typedef enum logic [5:0] {
    ST_IDLE = 6'b000001,
    ST_CMD = 6'b000010,
    ST_ADDR = 6'b000100,
    ST_DATA = 6'b001000,
    ST_IGNORE = 6'b010000,
    ST_RECOVER = 6'b100000
  } frame_state_t;

endpackage : flash_pkg

/* include/byte_stream_if.sv */
// Purpose: valid/ready byte stream between table reader and output shifter
// Assumes: single clock domain
// Notes: a word moves on a cycle with valid and ready both high
`timescale 1ns/1ns
`default_nettype none
interface byte_stream_if;
  import flash_pkg::*;
  logic [DATA_W-1:0] data;
  logic valid;
  logic ready;
  modport src (output data, output valid, input ready);
  modport snk (input data, input valid, output ready);
endinterface : byte_stream_if
`default_nettype wire

/* hdl/byte_fifo.sv */
// Purpose: parameterised fifo with a registered read word
// Assumes: flush drops all content in one cycle
// Notes: holds DEPTH words in the array plus one in the output register
`timescale 1ns/1ns
`default_nettype none
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic flush,
  byte_stream_if.snk wr,
  byte_stream_if.src rd
);

  localparam int AW = $clog2(DEPTH);

  // ==========================================================================
  // storage
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_ptr_q;
  logic [AW-1:0] rd_ptr_q;
  logic [AW:0] count_q;
  logic [WIDTH-1:0] out_q;
  logic out_valid_q;
  logic push;
  logic pull;

  assign wr.ready = (count_q < (AW+1)'(DEPTH));
  assign push = wr.valid && wr.ready;
  assign pull = (count_q != '0) && (!out_valid_q || rd.ready);
  assign rd.data = out_q;
  assign rd.valid = out_valid_q;

  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem_q[wr_ptr_q] <= wr.data;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn || flush) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q <= '0;
    end else begin
      if (push) begin
        wr_ptr_q <= wr_ptr_q + AW'(1);
      end
      if (pull) begin
        rd_ptr_q <= rd_ptr_q + AW'(1);
      end
      count_q <= count_q + (AW+1)'(push) - (AW+1)'(pull);
    end
  end

  // ==========================================================================
  // output register
  always_ff @(posedge sys_clk) begin
    if (!resetn || flush) begin
      out_q <= '0;
      out_valid_q <= 1'b0;
    end else if (pull) begin
      out_q <= mem_q[rd_ptr_q];
      out_valid_q <= 1'b1;
    end else if (rd.ready) begin
      out_valid_q <= 1'b0;
    end
  end

endmodule : byte_fifo
`default_nettype wire

/* hdl/flash_reset_param_read.sv */
// Purpose: serial flash command decoder for software reset and parameter-table read
// Assumes: chip select, serial clock and serial input are asynchronous pins
// Notes: serial clock edges found by oversampling on sys_clk
//
// Functional notes
// - reset needs arm opcode 66h in one frame, execute 99h in the next.
// - reset action starts on the chip select rise ending the execute frame.
// - completed reset returns the device to its power-on state.
// - reset aborts erase or program, clears suspend and volatile status bits.
// - after the recovery time the device is back in standby taking commands.
// - data being written when reset hits may be left corrupted.
// - any other command after arm drops the armed state.
// - table read is 5Ah, 3 address bytes msb first, dummy byte, data.
// - only address bits 10 to 0 select the table byte.
// - opcode and address bits sampled on serial clock rising edges.
// - first data bit at falling edge of clock 39, msb first, falling edges.
// - address increments per byte while chip select low and clock runs.
// - chip select high ends the read; output stays high impedance.
// - header gives signature, revision 1.05, three headers, FFh at byte 7.
// - first header gives id 00h, rev 1.0, 16 dwords, pointer 000040h.
// - second header gives maker id, rev 1.0, 4 dwords, pointer 0000C0h.
`timescale 1ns/1ns
`default_nettype none
module flash_reset_param_read
  import flash_pkg::*;
#(
  // arbitrary maker identity value
  parameter logic [7:0] VENDOR_ID = 8'hA5,
  parameter int RST_RECOVERY_NS = RST_RECOVERY_NS_DEF
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic cs_n,
  input wire logic sck,
  input wire logic si,
  output logic so_out,
  output logic so_oe_n,
  input wire logic write_latch_set,
  input wire logic write_latch_clr,
  input wire logic ready_n_set,
  input wire logic ready_n_clr,
  input wire logic suspend_set,
  input wire logic suspend_clr,
  output logic write_latch_bit,
  output logic ready_n_bit,
  output logic suspend_flag,
  output logic abort_write,
  output logic reset_armed,
  output logic standby
);

  localparam int RST_RECOVERY_CYC_RAW = (RST_RECOVERY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RST_RECOVERY_CYC = (RST_RECOVERY_CYC_RAW < 1) ? 1 : RST_RECOVERY_CYC_RAW;

  // ==========================================================================
  // table lookup
  function automatic logic [7:0] byte_of(input logic [31:0] word, input logic [1:0] lane);
    byte_of = word[8*lane +: 8];
  endfunction : byte_of

  function automatic logic [7:0] table_byte(input logic [TABLE_ADDR_W-1:0] addr,
                                            input logic [7:0] vid);
    logic [TABLE_ADDR_W-1:0] word_ofs;
    word_ofs = {addr[TABLE_ADDR_W-1:2], 2'b00};
    unique case (word_ofs)
      OFS_PARAM_SIGNATURE: table_byte = byte_of(RST_PARAM_SIGNATURE, addr[1:0]);
      OFS_PARAM_HEADER_REVISION_COUNT: begin
        table_byte = byte_of(RST_PARAM_HEADER_REVISION_COUNT, addr[1:0]);
      end
      OFS_BASIC_TABLE_HEADER: table_byte = byte_of(RST_BASIC_TABLE_HEADER, addr[1:0]);
      OFS_BASIC_TABLE_POINTER: table_byte = byte_of(RST_BASIC_TABLE_POINTER, addr[1:0]);
      OFS_VENDOR_TABLE_HEADER: begin
        table_byte = byte_of({RST_VENDOR_TABLE_HEADER_UPPER, vid}, addr[1:0]);
      end
      OFS_VENDOR_TABLE_POINTER: table_byte = byte_of(RST_VENDOR_TABLE_POINTER, addr[1:0]);
      default: table_byte = BLANK_BYTE;
    endcase
  endfunction : table_byte

  // ==========================================================================
  // pin synchronisers and edge detection
  logic cs_n_m_q;
  logic cs_n_s_q;
  logic cs_n_p_q;
  logic sck_m_q;
  logic sck_s_q;
  logic sck_p_q;
  logic si_m_q;
  logic si_s_q;
  logic sck_rise;
  logic sck_fall;
  logic cs_rise;
  logic cs_low;

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      cs_n_m_q <= 1'b1;
      cs_n_s_q <= 1'b1;
      cs_n_p_q <= 1'b1;
      sck_m_q <= 1'b0;
      sck_s_q <= 1'b0;
      sck_p_q <= 1'b0;
      si_m_q <= 1'b0;
      si_s_q <= 1'b0;
    end else begin
      cs_n_m_q <= cs_n;
      cs_n_s_q <= cs_n_m_q;
      cs_n_p_q <= cs_n_s_q;
      sck_m_q <= sck;
      sck_s_q <= sck_m_q;
      sck_p_q <= sck_s_q;
      si_m_q <= si;
      si_s_q <= si_m_q;
    end
  end

  // serial clock edges count only while the chip is selected
  assign cs_low = !cs_n_s_q;
  assign cs_rise = cs_n_s_q && !cs_n_p_q;
  assign sck_rise = cs_low && sck_s_q && !sck_p_q;
  assign sck_fall = cs_low && !sck_s_q && sck_p_q;

  // ==========================================================================
  // frame bit counter and input shifter
  logic [5:0] bit_cnt_q;
  logic [7:0] in_sh_q;
  logic [7:0] in_byte;

  assign in_byte = {in_sh_q[6:0], si_s_q};

  always_ff @(posedge sys_clk) begin
    if (!resetn || !cs_low) begin
      bit_cnt_q <= '0;
      in_sh_q <= '0;
    end else if (sck_rise) begin
      in_sh_q <= in_byte;
      if (bit_cnt_q != BITS_DATA_START) begin
        bit_cnt_q <= bit_cnt_q + 6'h01;
      end
    end
  end

  // ==========================================================================
  // frame decoder
  frame_state_t state_q;
  frame_state_t state_d;
  logic [7:0] opcode_q;
  logic [31:0] recover_cnt_q;
  logic recover_done;
  logic exec_reset;

  assign recover_done = (recover_cnt_q == 32'(RST_RECOVERY_CYC - 1));
  assign exec_reset = cs_rise && (state_q == ST_IGNORE || state_q == ST_CMD)
                      && opcode_q == OP_RESET_EXEC && reset_armed;

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_IDLE: begin
        if (cs_low) begin
          state_d = ST_CMD;
        end
      end
      ST_CMD: begin
        if (cs_rise) begin
          state_d = ST_IDLE;
        end else if (sck_rise && bit_cnt_q == BITS_OPCODE - 6'h01) begin
          state_d = (in_byte == OP_PARAM_READ) ? ST_ADDR : ST_IGNORE;
        end
      end
      ST_ADDR: begin
        if (cs_rise) begin
          state_d = ST_IDLE;
        end else if (sck_rise && bit_cnt_q == BITS_ADDR_END - 6'h01) begin
          state_d = ST_DATA;
        end
      end
      ST_DATA, ST_IGNORE: begin
        if (cs_rise) begin
          state_d = ST_IDLE;
        end
      end
      // frames arriving during recovery are swallowed whole
      ST_RECOVER: begin
        if (recover_done && !cs_low) begin
          state_d = ST_IDLE;
        end
      end
      default: state_d = ST_IDLE;
    endcase
    if (exec_reset) begin
      state_d = ST_RECOVER;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn || state_q == ST_IDLE) begin
      opcode_q <= '0;
    end else if (state_q == ST_CMD && sck_rise && bit_cnt_q == BITS_OPCODE - 6'h01) begin
      opcode_q <= in_byte;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn || state_q != ST_RECOVER) begin
      recover_cnt_q <= '0;
    end else if (!recover_done) begin
      recover_cnt_q <= recover_cnt_q + 32'h1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      standby <= 1'b1;
    end else begin
      standby <= (state_d != ST_RECOVER);
    end
  end

  // ==========================================================================
  // reset arming
  // arming is judged at the end of every frame of eight bits or more, except frames ending during recovery
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      reset_armed <= 1'b0;
    end else if (cs_rise && (state_q == ST_IGNORE || state_q == ST_DATA || state_q == ST_ADDR)) begin
      reset_armed <= (opcode_q == OP_RESET_ARM);
    end else if (exec_reset) begin
      reset_armed <= 1'b0;
    end
  end

  // ==========================================================================
  // volatile status and write abort
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      abort_write <= 1'b0;
    end else begin
      abort_write <= exec_reset;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      write_latch_bit <= 1'b0;
      ready_n_bit <= 1'b0;
      suspend_flag <= 1'b0;
    end else begin
      // a hardware set in the clearing cycle wins
      write_latch_bit <= write_latch_set || (write_latch_bit && !write_latch_clr && !exec_reset);
      ready_n_bit <= ready_n_set || (ready_n_bit && !ready_n_clr && !exec_reset);
      suspend_flag <= suspend_set || (suspend_flag && !suspend_clr && !exec_reset);
    end
  end

  // ==========================================================================
  // table reader into the fifo
  byte_stream_if fill_if ();
  byte_stream_if drain_if ();
  logic [TABLE_ADDR_W-1:0] rd_addr_q;
  logic [23:0] addr_sh_q;
  logic reading;

  assign reading = (state_q == ST_DATA);
  assign fill_if.valid = reading;
  assign fill_if.data = table_byte(rd_addr_q, VENDOR_ID);

  always_ff @(posedge sys_clk) begin
    if (!resetn || state_q == ST_IDLE) begin
      addr_sh_q <= '0;
    end else if (state_q == ST_ADDR && sck_rise) begin
      addr_sh_q <= {addr_sh_q[22:0], si_s_q};
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      rd_addr_q <= '0;
    end else if (state_q == ST_ADDR) begin
      rd_addr_q <= {addr_sh_q[TABLE_ADDR_W-2:0], si_s_q};
    end else if (fill_if.valid && fill_if.ready) begin
      rd_addr_q <= rd_addr_q + 11'h001;
    end
  end

  byte_fifo #(
    .WIDTH(DATA_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .flush(!reading),
    .wr(fill_if),
    .rd(drain_if)
  );

  // ==========================================================================
  // output shifter
  logic [2:0] out_idx_q;
  logic [7:0] out_sh_q;
  logic [7:0] load_byte;
  logic shift_now;

  assign shift_now = reading && sck_fall && bit_cnt_q == BITS_DATA_START;
  // a byte not yet prefetched goes out blank
  assign load_byte = drain_if.valid ? drain_if.data : BLANK_BYTE;
  assign drain_if.ready = shift_now && out_idx_q == 3'h0;

  always_ff @(posedge sys_clk) begin
    if (!resetn || !reading) begin
      out_idx_q <= '0;
      out_sh_q <= '0;
    end else if (shift_now) begin
      out_idx_q <= out_idx_q + 3'h1;
      out_sh_q <= (out_idx_q == 3'h0) ? {load_byte[6:0], 1'b0} : {out_sh_q[6:0], 1'b0};
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn || !reading) begin
      so_out <= 1'b0;
      so_oe_n <= 1'b1;
    end else if (shift_now) begin
      so_out <= (out_idx_q == 3'h0) ? load_byte[7] : out_sh_q[7];
      so_oe_n <= 1'b0;
    end
  end

endmodule : flash_reset_param_read
`default_nettype wire

/* bench/flash_reset_param_read_props.sv */
// Purpose: port checks for the reset and parameter-table command block
// Assumes: one sys_clk domain, resetn synchronous active low
// Notes: bound to every instance of the block
`timescale 1ns/1ns
`default_nettype none
module flash_reset_param_read_checker
  import flash_pkg::*;
#(
  parameter int RST_RECOVERY_NS = RST_RECOVERY_NS_DEF
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic cs_n,
  input wire logic sck,
  input wire logic si,
  input wire logic so_out,
  input wire logic so_oe_n,
  input wire logic write_latch_set,
  input wire logic ready_n_set,
  input wire logic suspend_set,
  input wire logic write_latch_bit,
  input wire logic ready_n_bit,
  input wire logic suspend_flag,
  input wire logic abort_write,
  input wire logic reset_armed,
  input wire logic standby
);
  localparam int REC = RST_RECOVERY_NS / CLK_PERIOD_NS;
  logic cs_q;
  logic sck_q;
  logic [7:0] rise_q;
  logic [7:0] fall_q;
  logic [7:0] nrise_q;
  logic [15:0] low_q;
  // ==========================================================================
  // helper counters
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      cs_q <= 1'b1;
      sck_q <= 1'b0;
      rise_q <= 8'hFF;
      fall_q <= 8'hFF;
      nrise_q <= 8'h00;
      low_q <= 16'h0000;
    end else begin
      cs_q <= cs_n;
      sck_q <= sck;
      rise_q <= (cs_n && !cs_q) ? 8'h00 : rise_q + 8'(rise_q != 8'hFF);
      fall_q <= (!sck && sck_q) ? 8'h00 : fall_q + 8'(fall_q != 8'hFF);
      nrise_q <= cs_n ? 8'h00 : nrise_q + 8'(sck && !sck_q);
      low_q <= standby ? 16'h0000 : low_q + 16'h0001;
    end
  end
  // ==========================================================================
  // assertions
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  sequence s_clean;
    !write_latch_bit && !ready_n_bit && !suspend_flag;
  endsequence
  sequence s_fire;
    abort_write ##1 !abort_write;
  endsequence
  AST_OE_IDLE: assert property (cs_n [*6] |-> so_oe_n)
    else $error("output driven while deselected");
  AST_OE_CAUSE: assert property ($fell(so_oe_n) |-> !cs_n && fall_q < 8'h08 && nrise_q == 8'h28)
    else $error("output enabled at wrong clock");
  AST_SO_STABLE: assert property (!so_oe_n && !$past(so_oe_n) && $changed(so_out)
    |-> fall_q < 8'h08)
    else $error("output bit changed away from falling edge");
  AST_ABORT_PULSE: assert property ($rose(abort_write) |-> s_fire)
    else $error("abort not one cycle");
  AST_ABORT_CLEARS: assert property (abort_write && !(write_latch_set || ready_n_set ||
    suspend_set) |-> ##[0:2] s_clean)
    else $error("status bits not cleared by reset");
  AST_ABORT_CAUSE: assert property (abort_write |-> rise_q < 8'h0A && $past(reset_armed, 2))
    else $error("abort without armed frame end");
  AST_STANDBY_CAUSE: assert property ($fell(standby) |-> rise_q < 8'h0A && $past(reset_armed, 2))
    else $error("recovery without armed frame end");
  AST_STANDBY_LEN: assert property ($rose(standby) |-> low_q >= REC - 1 && low_q <= REC + 1)
    else $error("recovery length wrong");
  AST_ARM_CAUSE: assert property ($rose(reset_armed) |-> cs_n && rise_q < 8'h0A)
    else $error("armed outside frame end");
endmodule : flash_reset_param_read_checker
bind flash_reset_param_read flash_reset_param_read_checker #(.RST_RECOVERY_NS(RST_RECOVERY_NS))
  props (.sys_clk(sys_clk), .resetn(resetn), .cs_n(cs_n), .sck(sck), .si(si),
  .so_out(so_out), .so_oe_n(so_oe_n), .write_latch_set(write_latch_set),
  .ready_n_set(ready_n_set), .suspend_set(suspend_set), .write_latch_bit(write_latch_bit),
  .ready_n_bit(ready_n_bit), .suspend_flag(suspend_flag), .abort_write(abort_write),
  .reset_armed(reset_armed), .standby(standby));
`default_nettype wire

/* bench/spi_host_model.sv */
// Purpose: serial host driving chip select, clock and data in mode 0
// Assumes: serial clock 80 ns period, idle low between frames
// Notes: each received byte is posted on event got
`timescale 1ns/1ns
`default_nettype none
module spi_host_model (
  output logic cs_n,
  output logic sck,
  output logic si,
  input wire logic so_out,
  input wire logic so_oe_n
);
  logic [7:0] rx;
  logic oe_ok;
  logic so_line;
  // a released line shows the inverse of the data value
  assign so_line = (so_oe_n === 1'b0) ? so_out : ~so_out;
  event got;
  initial begin
    cs_n = 1'b1;
    sck = 1'b0;
    si = 1'b0;
  end
  task automatic frame(input logic [39:0] tx, input int ntx, input int nrx);
    int i;
    #3 cs_n = 1'b0;
    #40;
    for (i = 0; i < ntx; i++) begin
      si = tx[39-i];
      #40 sck = 1'b1;
      #40 sck = 1'b0;
    end
    for (i = 0; i < nrx * 8; i++) begin
      si = ~si;
      if (i % 8 == 0) oe_ok = 1'b1;
      #40 sck = 1'b1;
      rx = {rx[6:0], so_line};
      oe_ok = oe_ok && (so_oe_n === 1'b0);
      if (i % 8 == 7) -> got;
      #40 sck = 1'b0;
    end
    #40 cs_n = 1'b1;
    si = ~si;
    #40;
  endtask : frame
endmodule : spi_host_model
`default_nettype wire

/* bench/flash_reset_param_read_bench.sv */
// Purpose: self-checking bench for the reset and parameter-table block
// Assumes: recovery shortened to 200 ns
// Notes: table bytes checked through an expectation queue
`timescale 1ns/1ns
`default_nettype none
module flash_reset_param_read_bench;
  import flash_pkg::*;
  localparam logic [7:0] VID = 8'h3C; // arbitrary maker identity value
  logic sys_clk, resetn, cs_n, sck, si, so_out, so_oe_n;
  logic [5:0] st_in;
  logic wl, rn, su, abort_write, reset_armed, standby;
  logic [7:0] exp_q [$];
  logic [7:0] e;
  logic [31:0] r;
  int failures, checks, aborts, cyc, i;
  flash_reset_param_read #(.VENDOR_ID(VID), .RST_RECOVERY_NS(200)) dut (
    .sys_clk(sys_clk), .resetn(resetn), .cs_n(cs_n), .sck(sck), .si(si),
    .so_out(so_out), .so_oe_n(so_oe_n), .write_latch_set(st_in[5]),
    .write_latch_clr(st_in[4]), .ready_n_set(st_in[3]), .ready_n_clr(st_in[2]),
    .suspend_set(st_in[1]), .suspend_clr(st_in[0]), .write_latch_bit(wl),
    .ready_n_bit(rn), .suspend_flag(su), .abort_write(abort_write),
    .reset_armed(reset_armed), .standby(standby));
  spi_host_model host (.cs_n(cs_n), .sck(sck), .si(si), .so_out(so_out), .so_oe_n(so_oe_n));
  function automatic logic [7:0] tbyte(input logic [10:0] a);
    logic [7:0] h [0:23];
    h = '{8'h53, 8'h46, 8'h44, 8'h50, 8'h05, 8'h01, 8'h02, 8'hFF, 8'h00, 8'h00, 8'h01, 8'h10,
      8'h40, 8'h00, 8'h00, 8'hFF, VID, 8'h00, 8'h01, 8'h04, 8'hC0, 8'h00, 8'h00, 8'hFF};
    return (a < 11'h018) ? h[a[4:0]] : 8'hFF;
  endfunction : tbyte
  task automatic mism(input string m);
    failures++;
    $display("mismatch %0t %s", $time, m);
  endtask : mism
  task automatic chk(input logic g, input logic x, input string m);
    checks++;
    if (g !== x) mism(m);
  endtask : chk
  task automatic rd(input logic [23:0] a, input int n);
    int k;
    for (k = 0; k < n; k++) exp_q.push_back(tbyte(a[10:0] + 11'(k)));
    host.frame({OP_PARAM_READ, a, 8'h00}, 40, n);
  endtask : rd
  task automatic cmd(input logic [7:0] op);
    host.frame({op, 32'h00000000}, 8, 0);
    @(posedge sys_clk);
  endtask : cmd
  task automatic pulse(input logic [5:0] v);
    st_in <= v;
    @(posedge sys_clk);
    st_in <= 6'h00;
    repeat (3) @(posedge sys_clk);
  endtask : pulse
  task automatic report_and_stop;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : report_and_stop
  // ==========================================================================
  // clock, watchers and timeout
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cyc++;
    if (abort_write === 1'b1) aborts++;
    if (cyc == 40000) begin
      mism("timeout");
      report_and_stop();
    end
  end
  always @(host.got) begin
    checks++;
    if (exp_q.size() == 0) mism("byte not expected");
    else begin
      e = exp_q.pop_front();
      if (host.rx !== e || host.oe_ok !== 1'b1) mism("table byte");
    end
  end
  // ==========================================================================
  // tests
  initial begin
    resetn = 1'b0;
    st_in = 6'h00;
    r = $urandom(89);
    repeat (5) @(posedge sys_clk);
    resetn <= 1'b1;
    repeat (8) @(posedge sys_clk);
    rd(24'h000000, 26);
    $display("test header done");
    r = $urandom();
    rd({r[12:0], 11'h004}, 4);
    rd(24'h0007FF, 2);
    $display("test address done");
    @(posedge sys_clk);
    pulse(6'h2A);
    pulse(6'h04);
    chk(rn, 1'b0, "busy clear");
    pulse(6'h08);
    cmd(OP_RESET_ARM);
    chk(reset_armed, 1'b1, "armed");
    cmd(8'h05);
    chk(reset_armed, 1'b0, "arm dropped");
    cmd(OP_RESET_EXEC);
    repeat (10) @(posedge sys_clk);
    chk(aborts == 0 && standby && wl && rn && su, 1'b1, "unarmed execute acted");
    $display("test arm cancel done");
    cmd(OP_RESET_ARM);
    cmd(OP_RESET_EXEC);
    chk(aborts == 1 && !standby, 1'b1, "reset start");
    chk(wl || rn || su || reset_armed, 1'b0, "status after reset");
    for (i = 0; i < 200 && standby !== 1'b1; i++) @(posedge sys_clk);
    chk(standby, 1'b1, "standby after recovery");
    rd(24'h000010, 1);
    chk(exp_q.size() == 0, 1'b1, "bytes left");
    $display("test reset done");
    report_and_stop();
  end
endmodule : flash_reset_param_read_bench
`default_nettype wire
